// ### core/lcdc_cmd_decoder.v
// Command decoder, settings and display memory of the LCD segment driver.
`timescale 1ns/1ns
`include "lcdc_map.vh"

module lcdc_cmd_decoder #(
  parameter [19:0] FRAME_80_CYC = `LCDC_FRAME_80_CYC,
  parameter [23:0] BLINK_TICK_CYC = `LCDC_BLINK_TICK_CYC
) (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire [4:0] seg_addr_i,
  output reg [7:0] seg_data_o,
  output reg bias_half_o,
  output reg osc_run_o,
  output reg display_on_o,
  output reg frame_160_o,
  output reg frame_tick_o,
  output reg [1:0] blink_rate_o,
  output reg segments_blank_o,
  output reg pin_is_segment_o,
  output reg internal_adjust_on_o,
  output reg [3:0] trim_code_o,
  output reg bias_follower_amp_en_o,
  output reg bias_from_logic_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_WR = 2'h2;
  localparam [1:0] ST_RD = 2'h3;

  localparam [1:0] PH_FIRST = 2'h0;
  localparam [1:0] PH_CMD = 2'h1;
  localparam [1:0] PH_SKIP = 2'h2;
  localparam [1:0] PH_DATA = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function [4:0] ptr_inc;
    input [4:0] p;
    begin
      if (p >= `LCDC_MEM_LAST) begin
        ptr_inc = 5'h00;
      end else begin
        ptr_inc = p + 5'h01;
      end
    end
  endfunction

  function [2:0] cmd_kind;
    input [7:0] b;
    begin
      if (b[7:5] == 3'b100 && b[1] == 1'b0) begin
        cmd_kind = `LCDC_KIND_MODE;
      end else if (b[7:5] == 3'b000) begin
        cmd_kind = `LCDC_KIND_PTR;
      end else if (b[7:2] == 6'b110000) begin
        cmd_kind = `LCDC_KIND_BLINK;
      end else if (b[7:6] == 2'b01) begin
        cmd_kind = `LCDC_KIND_ADJ;
      end else begin
        cmd_kind = `LCDC_KIND_NONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus edge and condition detection on the sampled lines.

  // History resets to the idle level, so no false START follows reset.
  reg scl_prev_reg;
  reg sda_prev_reg;
  wire scl_rise = scl_i & ~scl_prev_reg;
  wire scl_fall = ~scl_i & scl_prev_reg;
  wire bus_start = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
  wire bus_stop = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_i;
      sda_prev_reg <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine, command decode and display memory.

  reg [7:0] mem [0:`LCDC_MEM_WORDS-1];
  reg [1:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg host_ack_reg;
  reg [4:0] ptr_reg;
  reg [1:0] blink_reg;
  wire [2:0] rx_kind = cmd_kind(rx_reg);
  wire [4:0] ptr_next = ptr_inc(ptr_reg);
  wire [7:0] rd_word = mem[ptr_reg];
  wire [7:0] rd_word_next = mem[ptr_next];

  // Memory contents have no reset; only written over the bus.
  always @(posedge clk_sys_i) begin
    if (scl_fall && bit_cnt_reg == 4'h9 && state_reg == ST_WR &&
        phase_reg == PH_DATA && ptr_reg <= `LCDC_MEM_LAST) begin
      mem[ptr_reg] <= rx_reg;
    end
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_FIRST;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'hFF;
      host_ack_reg <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      ptr_reg <= `LCDC_PTR_RESET;
      frame_160_o <= 1'b0;
      osc_run_o <= 1'b0;
      display_on_o <= 1'b0;
      bias_half_o <= 1'b0;
      blink_reg <= 2'b00;
      pin_is_segment_o <= 1'b1;
      internal_adjust_on_o <= 1'b1;
      trim_code_o <= 4'h0;
    end else if (bus_start) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_reg < 4'h8) begin
          rx_reg <= {rx_reg[6:0], sda_i};
        end else if (bit_cnt_reg == 4'h8) begin
          host_ack_reg <= ~sda_i;
        end
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall) begin
        case (bit_cnt_reg)
          4'h8: begin
            if (state_reg == ST_ADDR) begin
              if (rx_reg[7:1] == `LCDC_SLAVE_ADDR) begin
                sda_oe_o <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_WR) begin
              sda_oe_o <= 1'b1;
            end else begin
              sda_oe_o <= 1'b0;
            end
          end
          4'h9: begin
            bit_cnt_reg <= 4'h0;
            sda_oe_o <= 1'b0;
            case (state_reg)
              ST_ADDR: begin
                phase_reg <= PH_FIRST;
                if (rx_reg[0]) begin
                  state_reg <= ST_RD;
                  sda_oe_o <= ~rd_word[7];
                  tx_reg <= {rd_word[6:0], 1'b1};
                end else begin
                  state_reg <= ST_WR;
                end
              end
              ST_RD: begin
                // Only an acknowledged byte moves the pointer, so a byte the
                // host refuses is offered again by the next read.
                if (host_ack_reg) begin
                  ptr_reg <= ptr_next;
                  sda_oe_o <= ~rd_word_next[7];
                  tx_reg <= {rd_word_next[6:0], 1'b1};
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
              ST_WR: begin
                // Settings change only here, after the acknowledge clock.
                case (phase_reg)
                  PH_SKIP: begin
                    phase_reg <= PH_CMD;
                  end
                  PH_DATA: begin
                    ptr_reg <= ptr_next;
                  end
                  default: begin
                    case (rx_kind)
                      `LCDC_KIND_PTR: begin
                        // A start beyond the last word is ignored, yet the
                        // bytes after it still land as data.
                        if (rx_reg[4:0] <= `LCDC_MEM_LAST) begin
                          ptr_reg <= rx_reg[4:0];
                        end
                        phase_reg <= PH_DATA;
                      end
                      `LCDC_KIND_MODE: begin
                        // A stopped oscillator keeps the display off.
                        frame_160_o <= rx_reg[`LCDC_MODE_BIT_FRAME];
                        osc_run_o <= rx_reg[`LCDC_MODE_BIT_OSC];
                        display_on_o <= rx_reg[`LCDC_MODE_BIT_OSC] &
                                        rx_reg[`LCDC_MODE_BIT_DISP];
                        bias_half_o <= rx_reg[`LCDC_MODE_BIT_BIAS];
                        phase_reg <= (phase_reg == PH_FIRST) ? PH_SKIP :
                                     PH_CMD;
                      end
                      `LCDC_KIND_BLINK: begin
                        blink_reg <= rx_reg[1:0];
                        phase_reg <= (phase_reg == PH_FIRST) ? PH_SKIP :
                                     PH_CMD;
                      end
                      `LCDC_KIND_ADJ: begin
                        pin_is_segment_o <= rx_reg[`LCDC_ADJ_BIT_PIN];
                        internal_adjust_on_o <= rx_reg[`LCDC_ADJ_BIT_ON];
                        trim_code_o <= rx_reg[3:0];
                        phase_reg <= (phase_reg == PH_FIRST) ? PH_SKIP :
                                     PH_CMD;
                      end
                      default: begin
                        phase_reg <= PH_CMD;
                      end
                    endcase
                  end
                endcase
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end
          default: begin
            // Shift the next read bit out while the clock is low.
            if (state_reg == ST_RD && bit_cnt_reg != 4'h0) begin
              sda_oe_o <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b1};
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame and blink timing. Both halt with the oscillator, so a stopped
  // oscillator freezes the blink phase rather than resetting it.

  reg [19:0] frame_cnt_reg;
  reg [23:0] blink_cnt_reg;
  reg [1:0] blink_tick_reg;
  reg blink_blank_reg;
  wire [19:0] frame_len = frame_160_o ? {1'b0, FRAME_80_CYC[19:1]} :
                          FRAME_80_CYC;
  reg [1:0] blink_ticks;

  // Half-periods of one, two and four ticks give 2, 1 and 0.5 Hz blinking.
  always @* begin
    case (blink_reg)
      2'b01: blink_ticks = 2'h0;
      2'b10: blink_ticks = 2'h1;
      2'b11: blink_ticks = 2'h3;
      default: blink_ticks = 2'h0;
    endcase
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_cnt_reg <= 20'h00000;
      frame_tick_o <= 1'b0;
      blink_cnt_reg <= 24'h000000;
      blink_tick_reg <= 2'h0;
      blink_blank_reg <= 1'b0;
    end else begin
      frame_tick_o <= 1'b0;
      if (osc_run_o) begin
        if (frame_cnt_reg >= frame_len - 20'h00001) begin
          frame_cnt_reg <= 20'h00000;
          frame_tick_o <= 1'b1;
        end else begin
          frame_cnt_reg <= frame_cnt_reg + 20'h00001;
        end
      end
      if (blink_reg == 2'b00) begin
        blink_cnt_reg <= 24'h000000;
        blink_tick_reg <= 2'h0;
        blink_blank_reg <= 1'b0;
      end else if (osc_run_o) begin
        if (blink_cnt_reg >= BLINK_TICK_CYC - 24'h000001) begin
          blink_cnt_reg <= 24'h000000;
          if (blink_tick_reg >= blink_ticks) begin
            blink_tick_reg <= 2'h0;
            blink_blank_reg <= ~blink_blank_reg;
          end else begin
            blink_tick_reg <= blink_tick_reg + 2'h1;
          end
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 24'h000001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered status outputs and segment memory read port.

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blink_rate_o <= 2'b00;
      segments_blank_o <= 1'b1;
      bias_follower_amp_en_o <= 1'b0;
      bias_from_logic_o <= 1'b0;
      seg_data_o <= 8'h00;
    end else begin
      blink_rate_o <= blink_reg;
      segments_blank_o <= ~display_on_o | blink_blank_reg;
      // The analog controls lag the settings by a clock; the bias network
      // settles far slower than that.
      bias_follower_amp_en_o <= (trim_code_o != 4'h0) &
        ~(pin_is_segment_o & ~internal_adjust_on_o);
      bias_from_logic_o <= pin_is_segment_o & ~internal_adjust_on_o;
      // Addresses past the last word read as zero rather than wrapping.
      if (seg_addr_i <= `LCDC_MEM_LAST) begin
        seg_data_o <= mem[seg_addr_i];
      end else begin
        seg_data_o <= 8'h00;
      end
    end
  end

endmodule // lcdc_cmd_decoder

// ### include/lcdc_map.vh
// Constants for the LCD driver command decoder.
// What this block does
// - Byte 100xxx0x is mode setting: frame, oscillator, display, bias bits.
// - Bias select 0 gives one-third bias, 1 gives one-half bias.
// - Oscillator off forces display off; both bits set turn display on.
// - Frame select 0 gives 80 Hz frames, 1 gives 160 Hz.
// - Mode state after power-on equals byte 80H.
// - Undefined command patterns leave existing settings untouched.
// - Byte 000xxxxx loads the five-bit display memory start pointer; values past 15H are ignored.
// - Display memory pointer starts at zero after power-on.
// - Pointer advancing past 15H wraps to 00H.
// - Byte 110000xx is the blink command; default byte C0H.
// - Blink field: 00 off, 01 2 Hz, 10 1 Hz, 11 0.5 Hz.
// - Blinking is off after power-on.
// - Byte 01xxxxxx is voltage adjust: pin function, adjust on, trim.
// - Pin bit 0 makes shared pin supply, 1 makes it a segment.
// - Segment pin with adjust off: follower off, trim ignored.
// - Trim 0000 disables the bias follower; other codes enable it except for a segment pin with adjust off.
// - After power-on adjust is on and shared pin is a segment.
// - Acknowledge only the fixed seven-bit slave address; bit 0 is read.
// - The byte right after a first mode, blink or adjust command code is discarded.
// - Pointer advances by one after each written data byte, and after each read byte the host acknowledges.
`ifndef LCDC_MAP_VH
`define LCDC_MAP_VH

`define LCDC_SLAVE_ADDR 7'h3F
`define LCDC_MEM_LAST 5'h15
`define LCDC_MEM_WORDS 22

`define LCDC_MODE_RESET 8'h80
`define LCDC_BLINK_RESET 8'hC0
`define LCDC_ADJ_RESET 8'h70
`define LCDC_PTR_RESET 5'h00

`define LCDC_MODE_BIT_FRAME 4
`define LCDC_MODE_BIT_OSC 3
`define LCDC_MODE_BIT_DISP 2
`define LCDC_MODE_BIT_BIAS 0
`define LCDC_ADJ_BIT_PIN 5
`define LCDC_ADJ_BIT_ON 4

`define LCDC_KIND_NONE 3'h0
`define LCDC_KIND_MODE 3'h1
`define LCDC_KIND_PTR 3'h2
`define LCDC_KIND_BLINK 3'h3
`define LCDC_KIND_ADJ 3'h4

// An 80 Hz frame of 12.5 ms and a 250 ms blink tick, in 50 MHz clocks.
`define LCDC_FRAME_80_CYC 20'h98968
`define LCDC_BLINK_TICK_CYC 24'hBEBC20

`endif

// ### tb/lcdc_cmd_asserts.sv
// Concurrent checks on the ports of the command decoder.
`timescale 1ns/1ns
module lcdc_cmd_asserts #(
  parameter [19:0] FRAME_80_CYC = 20'h98968,
  parameter [23:0] BLINK_TICK_CYC = 24'hBEBC20
) (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire osc_run_o,
  input wire display_on_o,
  input wire frame_160_o,
  input wire frame_tick_o,
  input wire [1:0] blink_rate_o,
  input wire segments_blank_o,
  input wire bias_half_o,
  input wire pin_is_segment_o,
  input wire internal_adjust_on_o,
  input wire [3:0] trim_code_o,
  input wire bias_follower_amp_en_o,
  input wire bias_from_logic_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic [19:0] gap;
  logic seen;
  // A period is only judged after a full one at a steady rate.
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap <= 20'h00000;
      seen <= 1'b0;
    end else begin
      gap <= frame_tick_o ? 20'h00001 : gap + 20'h00001;
      if (!osc_run_o || frame_160_o != $past(frame_160_o)) seen <= 1'b0;
      else if (frame_tick_o) seen <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_osc_gates_display: assert property (display_on_o |-> osc_run_o)
    else $error("display on with oscillator stopped");
  a_off_is_blank: assert property (!$past(display_on_o) |->
    segments_blank_o)
    else $error("segments driven while display off");
  a_follower_rule: assert property (bias_follower_amp_en_o ==
    ($past(trim_code_o) != 4'h0 &&
     !($past(pin_is_segment_o) && !$past(internal_adjust_on_o))))
    else $error("bias follower enable wrong");
  a_logic_bias: assert property (bias_from_logic_o ==
    ($past(pin_is_segment_o) && !$past(internal_adjust_on_o)))
    else $error("bias source wrong");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
  a_apply_on_low: assert property ($changed({bias_half_o, osc_run_o,
    frame_160_o, pin_is_segment_o, internal_adjust_on_o, trim_code_o})
    |-> !scl_i)
    else $error("setting changed before acknowledge ended");
  a_tick_needs_osc: assert property
    (frame_tick_o |-> osc_run_o || $past(osc_run_o))
    else $error("frame tick with oscillator stopped");
  a_frame_period: assert property (frame_tick_o && seen &&
    $stable(frame_160_o) |->
    gap == (frame_160_o ? (FRAME_80_CYC >> 1) : FRAME_80_CYC))
    else $error("frame period wrong");
  cover property (display_on_o && !segments_blank_o);
  cover property (frame_tick_o && frame_160_o);
  cover property (blink_rate_o == 2'b11 && segments_blank_o);
  cover property ($rose(sda_oe_o));
endmodule // lcdc_cmd_asserts

bind lcdc_cmd_decoder lcdc_cmd_asserts #(.FRAME_80_CYC(FRAME_80_CYC),
  .BLINK_TICK_CYC(BLINK_TICK_CYC)) u_chk (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .osc_run_o(osc_run_o), .display_on_o(display_on_o),
  .frame_160_o(frame_160_o), .frame_tick_o(frame_tick_o),
  .blink_rate_o(blink_rate_o), .segments_blank_o(segments_blank_o),
  .bias_half_o(bias_half_o), .pin_is_segment_o(pin_is_segment_o),
  .internal_adjust_on_o(internal_adjust_on_o), .trim_code_o(trim_code_o),
  .bias_follower_amp_en_o(bias_follower_amp_en_o),
  .bias_from_logic_o(bias_from_logic_o));

// ### tb/lcdc_host_model.sv
// Two-wire bus master model standing in for the host controller.
`timescale 1ns/1ns
module lcdc_host_model (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv;
  // The line has a pull-up, so it reads high unless a party pulls it low.
  assign sda_o = drv & ~sda_oe_i;
  initial begin
    scl_o = 1'b1;
    drv = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic hc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    drv = 1'b1;
    hc(4);
    scl_o = 1'b1;
    hc(4);
    drv = 1'b0;
    hc(4);
    scl_o = 1'b0;
    hc(2);
  endtask
  task automatic stop();
    drv = 1'b0;
    hc(2);
    scl_o = 1'b1;
    hc(4);
    drv = 1'b1;
    hc(4);
  endtask
  // Sends nine bits MSB first; each returned bit is the line at the end
  // of its high phase, so the last one carries the acknowledge.
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      drv = d[i];
      hc(4);
      scl_o = 1'b1;
      hc(4);
      q[i] = sda_o;
      scl_o = 1'b0;
      hc(2);
    end
  endtask
endmodule // lcdc_host_model

// ### tb/tb_lcd_driver_command_decoder.sv
// Self-checking bench for the LCD driver command decoder.
`timescale 1ns/1ns
module tb_lcd_driver_command_decoder;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic scl, sda, sda_o, sda_oe, bias_half, osc, disp, f160, tick, blank;
  logic pin, adj, fol, logic_b;
  logic [4:0] seg_addr = 5'h00;
  logic [7:0] seg_data, m, r, v;
  logic [7:0] dv [3];
  logic [1:0] blink;
  logic [3:0] trim;
  logic [8:0] q;
  logic [31:0] seed = 32'hF952;
  int fail_count = 0;
  int checks_done = 0;
  int nb;
  always #10 clk_sys_i = ~clk_sys_i;
  lcdc_cmd_decoder #(.FRAME_80_CYC(20'h28), .BLINK_TICK_CYC(24'h10)) u_dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .seg_addr_i(seg_addr),
    .seg_data_o(seg_data), .bias_half_o(bias_half), .osc_run_o(osc),
    .display_on_o(disp), .frame_160_o(f160), .frame_tick_o(tick),
    .blink_rate_o(blink), .segments_blank_o(blank),
    .pin_is_segment_o(pin), .internal_adjust_on_o(adj),
    .trim_code_o(trim), .bias_follower_amp_en_o(fol),
    .bias_from_logic_o(logic_b));
  lcdc_host_model u_host (.clk_i(clk_sys_i), .sda_oe_i(sda_oe),
    .scl_o(scl), .sda_o(sda));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] em(input logic [7:0] b);
    return {4'h0, b[0], b[3], b[3] & b[2], b[4]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic nk);
    u_host.xbyte({b, 1'b1}, q);
    chk("ack", 8'(q[0]), 8'(nk));
  endtask
  task automatic wr(input int n, input logic [7:0] a, b, c, d);
    logic [7:0] t [4];
    t = '{a, b, c, d};
    u_host.start();
    send(8'h7E, 1'b0);
    for (int i = 0; i < n; i++) send(t[i], 1'b0);
    u_host.stop();
  endtask
  task automatic rst();
    arst_n_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("mode", 8'({bias_half, osc, disp, f160}), 8'h00);
    chk("blink", 8'(blink), 8'h00);
    chk("pinadj", 8'({pin, adj}), 8'h03);
    chk("blank", 8'(blank), 8'h01);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(negedge clk_sys_i);
    chk("timeout", 8'h00, 8'h01);
    summarize();
  end
  initial begin
    rst();
    u_host.start();
    send(8'h70, 1'b1);
    u_host.stop();
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      m = {3'b100, 3'(k), 1'b0, r[0]};
      wr(2, m, 8'hC3, 8'h00, 8'h00);
      chk("mode", 8'({bias_half, osc, disp, f160}), em(m));
      chk("discard", 8'(blink), 8'h00);
      wr(2, m ^ 8'h1F, 8'h00, 8'h00, 8'h00);
      chk("undef", 8'({bias_half, osc, disp, f160}), em(m));
    end
    for (int j = 0; j < 2; j++) begin
      wr(2, j == 0 ? 8'h9C : 8'h8C, 8'hFF, 8'h00, 8'h00);
      repeat (150) @(negedge clk_sys_i);
      chk("lit", 8'(blank), 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      wr(3, 8'hC0 | 8'(k), 8'h41, 8'hC0 | 8'(k ^ 1), 8'h00);
      chk("rate", 8'(blink), 8'(k ^ 1));
      chk("pinadj", 8'({pin, adj}), 8'h03);
      nb = 0;
      repeat (300) @(negedge clk_sys_i) nb += int'(blank);
      chk("blinks", 8'(nb != 0), 8'(k != 1));
    end
    wr(2, 8'hC0, 8'hFF, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      v = i == 0 ? 8'h6A : (i == 1 ? 8'h70 : {2'b01, r[5:0]});
      if (v[5:0] == 6'h00) v[0] = 1'b1;
      wr(2, v, 8'hFF, 8'h00, 8'h00);
      chk("adj", 8'({pin, adj, trim}), 8'(v[5:0]));
      chk("fol", 8'(fol), 8'(v[3:0] != 4'h0 && v[5:4] != 2'b10));
      chk("vdd", 8'(logic_b), 8'(v[5:4] == 2'b10));
    end
    for (int k = 0; k < 3; k++) dv[k] = rnd();
    wr(4, 8'h14, dv[0], dv[1], dv[2]);
    for (int k = 0; k < 3; k++) begin
      seg_addr = k == 2 ? 5'h00 : 5'(5'h14 + k);
      repeat (2) @(negedge clk_sys_i);
      chk("mem", seg_data, dv[k]);
    end
    u_host.start();
    send(8'h7E, 1'b0);
    send(8'h14, 1'b0);
    u_host.start();
    send(8'h7F, 1'b0);
    for (int k = 0; k < 3; k++) begin
      u_host.xbyte({8'hFF, k == 2}, q);
      chk("rd", q[8:1], dv[k]);
    end
    u_host.stop();
    // A mid-run reset keeps memory; the refused read already left the pointer at zero.
    rst();
    u_host.start();
    send(8'h7F, 1'b0);
    u_host.xbyte(9'h1FF, q);
    chk("rd0", q[8:1], dv[2]);
    u_host.stop();
    summarize();
  end
endmodule // tb_lcd_driver_command_decoder
